// ---- pkg/dma_pkg.sv ----
// Constants and carrier types of the DMA channel register block
package dma_pkg;
    localparam int NUM_CH = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int IO_ADDR_W = 6;
    localparam int CH_W = 3;

    // IO address = {kind[2:0], channel[2:0]}
    localparam logic [2:0] KIND_ADDR = 3'h0;
    localparam logic [2:0] KIND_COUNT = 3'h1;
    localparam logic [2:0] KIND_COUNT_HI = 3'h2;
    localparam logic [2:0] KIND_LOW_PAGE = 3'h3;
    localparam logic [2:0] KIND_HIGH_PAGE = 3'h4;
    localparam logic [2:0] KIND_GLOBAL = 3'h5;
    // Global kind: channel field = {select[1:0], group}
    localparam logic [1:0] SEL_CMD = 2'h0;
    localparam logic [1:0] SEL_MODE = 2'h1;
    localparam logic [1:0] SEL_EXT = 2'h2;
    localparam logic [1:0] SEL_CLEAR = 2'h3;

    localparam int CMD_DISABLE_BIT = 2;
    localparam logic [7:0] CMD_RESET = 8'h00;

    localparam int MODE_AUTOINIT_BIT = 4;
    localparam int MODE_DEC_BIT = 5;
    localparam int MODE_TYPE_LSB = 6;
    localparam logic [1:0] MODE_CASCADE = 2'h3;
    // Verify, no autoinit, increment, demand
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [2:0] CASCADE_CH = 3'h4;

    localparam int EXT_SIZE_LSB = 2;
    localparam int EXT_EOP_IN_BIT = 6;
    localparam int EXT_STOP_BIT = 7;
    localparam logic [1:0] SIZE_8B = 2'h0;
    localparam logic [1:0] SIZE_16W = 2'h1;
    localparam logic [1:0] SIZE_32B = 2'h2;
    localparam logic [1:0] SIZE_16B = 2'h3;
    localparam logic [7:0] EXT_RESET_LOWER = 8'h00;
    localparam logic [7:0] EXT_RESET_UPPER = 8'h04;

    localparam logic [2:0] STEP_ONE = 3'h1;
    localparam logic [2:0] STEP_TWO = 3'h2;
    localparam logic [2:0] STEP_FOUR = 3'h4;

    localparam int COUNT_HI_LSB = 16;
    localparam logic [23:0] COUNT_ALL_ONES = 24'hFFFFFF;
    localparam logic [7:0] HIGH_PAGE_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    typedef struct packed {
        logic [2:0] chan;
        logic [2:0] nbytes;
    } xfer_req_type;

    typedef struct packed {
        logic [31:0] addr;
        logic [2:0] chan;
    } bus_out_type;
endpackage

// ---- logic/dma_channel_regs.sv ----
// Eight-channel DMA address, count and mode logic with request FIFO
`timescale 1ns/1ps

module xfer_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] fill_reg;
    logic [PW:0] fill_next;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];
    assign fill_next = fill_reg + (PW+1)'(push) - (PW+1)'(pop);

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + PW'(push);
            rd_ptr_reg <= rd_ptr_reg + PW'(pop);
            fill_reg <= fill_next;
            // Registered flags keep full and empty honest
            in_ready <= fill_next != FULL;
            out_valid <= fill_next != '0;
        end
    end
endmodule // xfer_fifo

// How it works
// - Each channel's 16-bit current address steps after every transfer.
// - Address and count are reached as two bytes through a byte pointer.
// - Autoinit reloads the address only on terminal count or end of process.
// - Shifted word mode drives bit 0 low and the programmed address on 16:1.
// - 24-bit count decrements per transfer; value plus one transfers run.
// - Terminal count fires when the count borrows below zero.
// - No autoinit leaves the count all ones; reload only at terminal count.
// - Writing the low or middle count byte clears the high count byte.
// - Count unit follows the size field: bytes, or words when shifted.
// - Base registers load with the current ones and are never read back.
// - Software writes base only together with current; reloads use base.
// - Write-only command register, cleared by reset or master clear.
// - Upper group disable also stops the lower group.
// - Mode writes pick the channel from data bits 1:0.
// - Mode resets to verify, no autoinit, increment, demand.
// - Channel 4 is always cascade.
// - Extended mode writes pick the channel from data bits 1:0.
// - Extended defaults: lower group 8-bit bytes, upper group shifted words.
// - Extended defaults return only on the hardware reset.
// - Byte mode takes any address and steps one.
// - Word mode steps the shifted address by one; page stays unshifted.
// - Low address bytes clear high page; a high page write goes 32-bit.
// - 16 and 32-bit byte modes step 2 or 4, count by bytes moved.
// - Extended bit 6 makes end of process an input; bit 7 is stored but has no effect.
module dma_channel_regs (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [dma_pkg::IO_ADDR_W-1:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    output logic [7:0] io_rdata,
    input wire dma_pkg::xfer_req_type req_data,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic end_of_process_signal_in,
    output dma_pkg::bus_out_type bus_out,
    output logic bus_valid,
    input wire logic bus_ready,
    output logic tc_pulse,
    output logic [dma_pkg::CH_W-1:0] tc_chan,
    output logic end_of_process_signal_out,
    output logic end_of_process_signal_oe
);
    import dma_pkg::*;

    function automatic logic [15:0] put_byte(input logic [15:0] v,
                                             input logic hi,
                                             input logic [7:0] d);
        put_byte = hi ? {d, v[7:0]} : {v[15:8], d};
    endfunction

    function automatic logic [2:0] step_of(input logic [1:0] size);
        case (size)
            SIZE_16B: step_of = STEP_TWO;
            SIZE_32B: step_of = STEP_FOUR;
            default: step_of = STEP_ONE;
        endcase
    endfunction

    function automatic logic is_byte_count(input logic [1:0] size);
        is_byte_count = (size == SIZE_16B) || (size == SIZE_32B);
    endfunction

    logic eop_meta_reg;
    logic eop_sync_reg;
    logic [15:0] cur_addr_reg [NUM_CH];
    logic [7:0] low_page_reg [NUM_CH];
    logic [7:0] high_page_reg [NUM_CH];
    logic [NUM_CH-1:0] ext_addr_reg;
    logic [23:0] cur_count_reg [NUM_CH];
    logic [15:0] base_addr_reg [NUM_CH];
    logic [7:0] base_low_reg [NUM_CH];
    logic [7:0] base_high_reg [NUM_CH];
    logic [23:0] base_count_reg [NUM_CH];
    logic [7:0] cmd_reg [2];
    logic [7:0] mode_reg [NUM_CH];
    logic [7:0] ext_reg [NUM_CH];
    logic [1:0] ptr_reg;

    logic [2:0] kind;
    logic [2:0] wch;
    logic [1:0] sel;
    logic grp;
    logic [2:0] mch;
    logic gwr;
    logic [1:0] clear_grp;
    logic byte_acc;
    logic cur_ptr;
    logic addr_lo_wr;

    assign kind = io_addr[5:3];
    assign wch = io_addr[2:0];
    assign sel = io_addr[2:1];
    assign grp = io_addr[0];
    // Mode and extended writes: group by address, channel by data
    assign mch = {grp, io_wdata[1:0]};
    assign gwr = io_wr && (kind == KIND_GLOBAL);
    assign clear_grp = (gwr && sel == SEL_CLEAR) ? {grp, !grp} : 2'b00;
    assign byte_acc = (io_wr || io_rd)
        && (kind == KIND_ADDR || kind == KIND_COUNT);
    assign cur_ptr = ptr_reg[wch[2]];
    assign addr_lo_wr = io_wr
        && (kind == KIND_ADDR || kind == KIND_LOW_PAGE);

    xfer_req_type head;
    logic head_valid;
    logic pop;
    logic [2:0] hch;
    logic [1:0] hsize;
    logic upper_on;
    logic lower_on;
    logic casc;
    logic act;
    logic [31:0] full_addr;
    logic [31:0] stepped;
    logic [2:0] dec_amt;
    logic [24:0] cnt_diff;
    logic eop_hit;
    logic tc;
    logic reload;

    xfer_fifo #(.WIDTH($bits(xfer_req_type)), .DEPTH(FIFO_DEPTH)) req_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_data(req_data),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .out_data(head),
        .out_valid(head_valid),
        .out_ready(pop)
    );

    assign hch = head.chan;
    assign hsize = ext_reg[hch][EXT_SIZE_LSB +: 2];
    assign upper_on = !cmd_reg[1][CMD_DISABLE_BIT];
    assign lower_on = upper_on && !cmd_reg[0][CMD_DISABLE_BIT];
    // Stalls the FIFO head; a full FIFO pushes back on the requester
    assign pop = head_valid && (hch[2] ? upper_on : lower_on)
        && (!bus_valid || bus_ready);
    // Cascade requests are consumed without address activity
    assign casc = mode_reg[hch][MODE_TYPE_LSB +: 2] == MODE_CASCADE;
    assign act = pop && !casc;
    assign full_addr = {high_page_reg[hch], low_page_reg[hch],
                        cur_addr_reg[hch]};
    // Step size from the size field
    assign stepped = mode_reg[hch][MODE_DEC_BIT]
        ? full_addr - {29'h0, step_of(hsize)}
        : full_addr + {29'h0, step_of(hsize)};
    // Count unit follows the size field
    assign dec_amt = is_byte_count(hsize) ? head.nbytes : STEP_ONE;
    assign cnt_diff = {1'b0, cur_count_reg[hch]} - {22'h0, dec_amt};
    // Input direction lets the peripheral end the buffer
    assign eop_hit = eop_sync_reg && ext_reg[hch][EXT_EOP_IN_BIT];
    // Borrow out of the count is terminal count
    assign tc = cnt_diff[24] || eop_hit;
    assign reload = tc && mode_reg[hch][MODE_AUTOINIT_BIT];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            eop_meta_reg <= 1'b0;
            eop_sync_reg <= 1'b0;
        end else begin
            eop_meta_reg <= end_of_process_signal_in;
            eop_sync_reg <= eop_meta_reg;
        end
    end

    // Software write wins over a same-cycle transfer step
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cur_addr_reg[c] <= '0;
                low_page_reg[c] <= '0;
                high_page_reg[c] <= HIGH_PAGE_RESET;
            end
            ext_addr_reg <= '0;
        end else begin
            if (act) begin
                if (reload) begin
                    cur_addr_reg[hch] <= base_addr_reg[hch];
                    low_page_reg[hch] <= base_low_reg[hch];
                    high_page_reg[hch] <= base_high_reg[hch];
                end else if (ext_addr_reg[hch]) begin
                    {high_page_reg[hch], low_page_reg[hch],
                     cur_addr_reg[hch]} <= stepped;
                end else begin
                    // Compatible mode wraps within 16 bits
                    cur_addr_reg[hch] <= stepped[15:0];
                end
            end
            if (io_wr && kind == KIND_ADDR) begin
                cur_addr_reg[wch] <= put_byte(cur_addr_reg[wch], cur_ptr,
                                              io_wdata);
            end
            if (io_wr && kind == KIND_LOW_PAGE) begin
                low_page_reg[wch] <= io_wdata;
            end
            if (addr_lo_wr) begin
                high_page_reg[wch] <= HIGH_PAGE_RESET;
                ext_addr_reg[wch] <= 1'b0;
            end
            if (io_wr && kind == KIND_HIGH_PAGE) begin
                high_page_reg[wch] <= io_wdata;
                ext_addr_reg[wch] <= 1'b1;
            end
            for (int c = 0; c < NUM_CH; c++) begin
                if (clear_grp[c / 4]) begin
                    ext_addr_reg[c] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cur_count_reg[c] <= '0;
            end
        end else begin
            if (act) begin
                // Decrement, hold all ones or reload
                if (reload) begin
                    cur_count_reg[hch] <= base_count_reg[hch];
                end else if (tc) begin
                    cur_count_reg[hch] <= COUNT_ALL_ONES;
                end else begin
                    cur_count_reg[hch] <= cnt_diff[23:0];
                end
            end
            // Low or middle byte clears high byte
            if (io_wr && kind == KIND_COUNT) begin
                cur_count_reg[wch] <= {8'h00, put_byte(
                    cur_count_reg[wch][15:0], cur_ptr, io_wdata)};
            end
            if (io_wr && kind == KIND_COUNT_HI) begin
                cur_count_reg[wch][COUNT_HI_LSB +: 8] <= io_wdata;
            end
        end
    end

    // Base copies follow every current write
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                base_addr_reg[c] <= '0;
                base_low_reg[c] <= '0;
                base_high_reg[c] <= HIGH_PAGE_RESET;
                base_count_reg[c] <= '0;
            end
        end else if (io_wr) begin
            unique case (kind)
                KIND_ADDR: begin
                    base_addr_reg[wch] <= put_byte(base_addr_reg[wch],
                                                   cur_ptr, io_wdata);
                    base_high_reg[wch] <= HIGH_PAGE_RESET;
                end
                KIND_LOW_PAGE: begin
                    base_low_reg[wch] <= io_wdata;
                    base_high_reg[wch] <= HIGH_PAGE_RESET;
                end
                KIND_HIGH_PAGE: base_high_reg[wch] <= io_wdata;
                KIND_COUNT: base_count_reg[wch] <= {8'h00, put_byte(
                    base_count_reg[wch][15:0], cur_ptr, io_wdata)};
                KIND_COUNT_HI:
                    base_count_reg[wch][COUNT_HI_LSB +: 8] <= io_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_reg[0] <= CMD_RESET;
            cmd_reg[1] <= CMD_RESET;
            for (int c = 0; c < NUM_CH; c++) begin
                mode_reg[c] <= (3'(c) == CASCADE_CH)
                    ? {MODE_CASCADE, MODE_RESET[5:0]} : MODE_RESET;
                ext_reg[c] <= (c < 4) ? EXT_RESET_LOWER : EXT_RESET_UPPER;
            end
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (clear_grp[g]) begin
                    cmd_reg[g] <= CMD_RESET;
                    for (int c = 4 * g; c < 4 * g + 4; c++) begin
                        mode_reg[c] <= (3'(c) == CASCADE_CH)
                            ? {MODE_CASCADE, MODE_RESET[5:0]} : MODE_RESET;
                    end
                end
            end
            if (gwr && sel == SEL_CMD) begin
                cmd_reg[grp] <= io_wdata;
            end
            // Channel from data, channel 4 kept cascade
            if (gwr && sel == SEL_MODE) begin
                mode_reg[mch] <= (mch == CASCADE_CH)
                    ? {MODE_CASCADE, io_wdata[5:0]} : io_wdata;
            end
            if (gwr && sel == SEL_EXT) begin
                ext_reg[mch] <= io_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_reg <= '0;
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (clear_grp[g]) begin
                    ptr_reg[g] <= 1'b0;
                end
            end
            if (byte_acc) begin
                ptr_reg[wch[2]] <= !cur_ptr;
            end
        end
    end

    // Base, command and mode registers have no read path
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            io_rdata <= READ_IDLE;
        end else if (io_rd) begin
            unique case (kind)
                KIND_ADDR: io_rdata <= cur_ptr ? cur_addr_reg[wch][15:8]
                                               : cur_addr_reg[wch][7:0];
                KIND_COUNT: io_rdata <= cur_ptr ? cur_count_reg[wch][15:8]
                                                : cur_count_reg[wch][7:0];
                KIND_COUNT_HI:
                    io_rdata <= cur_count_reg[wch][COUNT_HI_LSB +: 8];
                KIND_LOW_PAGE: io_rdata <= low_page_reg[wch];
                KIND_HIGH_PAGE: io_rdata <= high_page_reg[wch];
                default: io_rdata <= READ_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_out <= '0;
            bus_valid <= 1'b0;
            tc_pulse <= 1'b0;
            tc_chan <= '0;
            end_of_process_signal_out <= 1'b0;
            end_of_process_signal_oe <= 1'b0;
        end else begin
            if (act) begin
                bus_valid <= 1'b1;
                bus_out.addr <= (hsize == SIZE_16W)
                    ? {full_addr[31:17], full_addr[15:0], 1'b0} : full_addr;
                bus_out.chan <= hch;
                end_of_process_signal_oe <= !ext_reg[hch][EXT_EOP_IN_BIT];
            end else if (bus_ready) begin
                bus_valid <= 1'b0;
            end
            tc_pulse <= act && tc;
            if (act && tc) begin
                tc_chan <= hch;
            end
            end_of_process_signal_out <= act && tc
                && !ext_reg[hch][EXT_EOP_IN_BIT];
        end
    end

    sequence s_lower_clear;
        gwr && sel == SEL_CLEAR && !grp;
    endsequence

    property p_cmd_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        s_lower_clear |=> cmd_reg[0] == CMD_RESET && mode_reg[1] == MODE_RESET;
    endproperty
    a_cmd_clear: assert property (p_cmd_clear)
        else $error("command or mode not cleared by master clear");

    property p_ext_keep;
        @(posedge ref_clk) disable iff (sys_rst)
        s_lower_clear |=> $stable(ext_reg[0]) && $stable(ext_reg[3]);
    endproperty
    a_ext_keep: assert property (p_ext_keep)
        else $error("extended mode changed by master clear");

    property p_ch4_cascade;
        @(posedge ref_clk) disable iff (sys_rst)
        gwr && sel == SEL_MODE && mch == CASCADE_CH |=>
            mode_reg[CASCADE_CH][MODE_TYPE_LSB +: 2] == MODE_CASCADE;
    endproperty
    a_ch4_cascade: assert property (p_ch4_cascade)
        else $error("channel 4 left cascade mode");

    property p_count_hi;
        logic [2:0] c;
        @(posedge ref_clk) disable iff (sys_rst)
        (io_wr && kind == KIND_COUNT, c = wch) |=>
            cur_count_reg[c][COUNT_HI_LSB +: 8] == 8'h00;
    endproperty
    a_count_hi: assert property (p_count_hi)
        else $error("high count byte not cleared");

    property p_page_compat;
        logic [2:0] c;
        @(posedge ref_clk) disable iff (sys_rst)
        (addr_lo_wr, c = wch) |=>
            !ext_addr_reg[c] && high_page_reg[c] == HIGH_PAGE_RESET;
    endproperty
    a_page_compat: assert property (p_page_compat)
        else $error("lower address write kept extended addressing");

    property p_byte_ptr;
        logic g;
        logic v;
        @(posedge ref_clk) disable iff (sys_rst)
        (byte_acc && clear_grp == 2'b00, g = wch[2], v = cur_ptr) |=>
            ptr_reg[g] == !v;
    endproperty
    a_byte_ptr: assert property (p_byte_ptr)
        else $error("byte pointer did not toggle");

    property p_group_stop;
        @(posedge ref_clk) disable iff (sys_rst)
        cmd_reg[1][CMD_DISABLE_BIT] && head_valid |-> !pop;
    endproperty
    a_group_stop: assert property (p_group_stop)
        else $error("transfer taken while upper group disabled");

    property p_shift;
        @(posedge ref_clk) disable iff (sys_rst)
        act && hsize == SIZE_16W |=> bus_valid && bus_out.addr[0] == 1'b0
            && bus_out.addr[16:1] == $past(cur_addr_reg[hch]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("shifted word address wrong");

    sequence s_tc_step;
        act && tc && !io_wr;
    endsequence

    property p_tc_hold;
        logic [2:0] c;
        @(posedge ref_clk) disable iff (sys_rst)
        (s_tc_step and !reload, c = hch) |=> tc_pulse && tc_chan == c
            && cur_count_reg[c] == COUNT_ALL_ONES;
    endproperty
    a_tc_hold: assert property (p_tc_hold)
        else $error("count not all ones after terminal count");

    property p_reload;
        logic [2:0] c;
        @(posedge ref_clk) disable iff (sys_rst)
        (s_tc_step and reload, c = hch) |=> tc_pulse
            && cur_addr_reg[c] == base_addr_reg[c]
            && cur_count_reg[c] == base_count_reg[c];
    endproperty
    a_reload: assert property (p_reload)
        else $error("autoinitialization did not restore base");
endmodule // dma_channel_regs

// ---- test/bus_sink.sv ----
// Far-side bus sink with a fixed stall rhythm
`timescale 1ns/1ps
module bus_sink (
    input wire logic ref_clk,
    input wire logic sys_rst,
    output logic bus_ready
);
    logic [1:0] phase_reg;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end
    // Ready one cycle in four so outputs must hold
    assign bus_ready = (phase_reg == 2'h3);
endmodule // bus_sink

// ---- test/testbench.sv ----
// Self-checking bench for the DMA channel register block
`timescale 1ns/1ps
module testbench;
    import dma_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
    logic req_valid = 1'b0, eop_in = 1'b0, rd_seen = 1'b0;
    logic bus_ready, bus_valid, req_ready, tc_pulse, eop_out, eop_oe;
    logic [2:0] tc_chan;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, io_rdata;
    logic [15:0] a, b;
    xfer_req_type req_data = '0;
    bus_out_type bus_out;
    logic [7:0] exp_rd[$];
    logic [35:0] exp_bus[$], exp_tc[$];
    int n_mismatch = 0, check_count = 0, seed = 20108;
    always #50 ref_clk = ~ref_clk;
    dma_channel_regs u_dma_channel_regs (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .req_data(req_data), .req_valid(req_valid), .req_ready(req_ready),
        .end_of_process_signal_in(eop_in), .bus_out(bus_out),
        .bus_valid(bus_valid), .bus_ready(bus_ready), .tc_pulse(tc_pulse),
        .tc_chan(tc_chan), .end_of_process_signal_out(eop_out),
        .end_of_process_signal_oe(eop_oe));
    bus_sink u_bus_sink (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .bus_ready(bus_ready));
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Oldest note first; bus notes are {oe, addr, chan}
    always @(posedge ref_clk) begin
        rd_seen <= io_rd;
        if (rd_seen) check(36'(io_rdata), 36'(exp_rd.pop_front()));
        if (bus_valid && bus_ready) begin
            check({eop_oe, bus_out}, exp_bus.pop_front());
        end
        if (tc_pulse) begin
            check(36'({eop_out, tc_chan}), exp_tc.pop_front());
        end
    end
    // For reads d is the expected byte
    task automatic acc(input logic rd, input logic [5:0] ad,
                       input logic [7:0] d);
        @(posedge ref_clk) #10;
        io_addr = ad;
        io_wdata = d;
        io_rd = rd;
        io_wr = !rd;
        if (rd) exp_rd.push_back(d);
        @(posedge ref_clk) #10;
        io_rd = 1'b0;
        io_wr = 1'b0;
    endtask
    task automatic xfer(input logic [2:0] ch, input logic [31:0] ad,
                        input logic oe);
        @(posedge ref_clk) #10;
        req_data = '{chan: ch, nbytes: 3'h1};
        req_valid = 1'b1;
        // Channel 4 is popped with no bus cycle
        if (ch != CASCADE_CH) exp_bus.push_back({oe, ad, ch});
        @(posedge ref_clk) #10;
        req_valid = 1'b0;
    endtask
    task automatic drain;
        for (int i = 0; i < 300 && exp_bus.size() + exp_tc.size() > 0;
             i++) begin
            @(posedge ref_clk);
        end
        if (exp_bus.size() + exp_tc.size() > 0) begin
            n_mismatch++;
            results();
        end
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        #10 sys_rst = 1'b0;
        a = 16'($random(seed));
        b = 16'($random(seed));
        acc(1'b0, 6'h00, a[7:0]);
        acc(1'b0, 6'h00, a[15:8]);
        acc(1'b1, 6'h00, a[7:0]);
        acc(1'b1, 6'h00, a[15:8]);
        acc(1'b0, 6'h10, 8'hAB);
        acc(1'b0, 6'h08, 8'h01);
        acc(1'b0, 6'h08, 8'h00);
        acc(1'b1, 6'h10, 8'h00);
        xfer(3'h0, {16'h0000, a}, 1'b1);
        exp_tc.push_back(36'h8);
        xfer(3'h0, {16'h0000, a + 16'h0001}, 1'b1);
        drain();
        acc(1'b1, 6'h08, 8'hFF);
        acc(1'b1, 6'h08, 8'hFF);
        acc(1'b1, 6'h10, 8'hFF);
        // Autoinit on channel 1 with a zero count
        acc(1'b0, 6'h2A, 8'h11);
        acc(1'b0, 6'h01, b[7:0]);
        acc(1'b0, 6'h01, b[15:8]);
        exp_tc.push_back(36'h9);
        exp_tc.push_back(36'h9);
        xfer(3'h1, {16'h0000, b}, 1'b1);
        xfer(3'h1, {16'h0000, b}, 1'b1);
        drain();
        // Upper disable holds a lower channel until cleared
        acc(1'b0, 6'h29, 8'h04);
        xfer(3'h0, {16'h0000, a + 16'h0002}, 1'b1);
        repeat (8) @(posedge ref_clk);
        check(36'(bus_valid), 36'h0);
        acc(1'b0, 6'h2E, 8'h00);
        check(36'(bus_valid), 36'h0);
        acc(1'b0, 6'h2F, 8'h00);
        drain();
        // End of process as input cuts channel 2 short
        acc(1'b0, 6'h2C, 8'h42);
        acc(1'b0, 6'h0A, 8'h05);
        acc(1'b0, 6'h0A, 8'h00);
        eop_in = 1'b1;
        exp_tc.push_back(36'h2);
        xfer(3'h2, 32'h00000000, 1'b0);
        drain();
        eop_in = 1'b0;
        acc(1'b0, 6'h05, 8'h34);
        acc(1'b0, 6'h05, 8'h12);
        acc(1'b0, 6'h2B, 8'h00);
        xfer(3'h4, 32'h00000000, 1'b1);
        exp_tc.push_back(36'hD);
        xfer(3'h5, 32'h00002468, 1'b1);
        drain();
        results();
    end
endmodule // testbench
